// ==== src/lss_pkg.sv ====
// constants, types and state layout of the load control source selector
//
// How it works
// - chosen loop source mode is broadcast on the internal bus and used here too
// - external contact mode: internal loop idle, three contacts give demand and direction
// - temperature limiter can be enabled even while the internal loop is idle
// - internal mode: load and heat request both come from the internal loop
// - internal mode: changeover contact picks first or second internal setpoint
// - bus setpoint mode: automation sends setpoints only, internal loop controls
// - bus setpoint mode: closed contact replaces bus setpoint by first setpoint
// - analog setpoint mode: setpoint from analog input 3, else as bus mode
// - external analog mode: loop idle, analog load sent as load messages
// - run selector off: standby whatever the demand, and no error shown
// - manual run: start needs controller release and start release in phase 21
// - manual run: load follows manual value, percent or stage, within working range
// - automatic run: start needs heat demand and start release in phase 21
// - run selector read only remotely, manual load value read and write
// - from any external mode a closed contact selects internal loop, first setpoint
// - contact open keeps the external mode, closed requests the internal loop
// - fuel change switches between modulating and multistage behaviour as needed
// - internal loop regulates temperature or pressure as the sensor dictates
// - modulating internal loop computes the load by a pid law on the deviation
package lss_pkg;
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned DEBOUNCE_TIME_US = 10000;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_MHZ;
   localparam int unsigned SAMPLE_TIME_MS = 100;
   localparam int unsigned SAMPLE_CYCLES = SAMPLE_TIME_MS * 1000 * CLK_MHZ;
   // register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] MANUAL_OFS = 8'h08;
   localparam logic [7:0] SP1_OFS = 8'h0c;
   localparam logic [7:0] SP2_OFS = 8'h10;
   localparam logic [7:0] BUS_SP_OFS = 8'h14;
   localparam logic [7:0] BUS_LOAD_OFS = 8'h18;
   localparam logic [7:0] RANGE_OFS = 8'h1c;
   localparam logic [7:0] GAIN_OFS = 8'h20;
   localparam logic [7:0] TLIMIT_OFS = 8'h24;
   localparam logic [7:0] STATUS_OFS = 8'h28;
   // field positions
   localparam int unsigned CTRL_TLIM_BIT = 0;
   localparam int unsigned CTRL_OIL_STAGE_BIT = 1;
   localparam int unsigned BUS_HEAT_BIT = 8;
   // reset values and load figures
   localparam logic [15:0] RANGE_RESET = 16'h6400;
   localparam logic [23:0] GAIN_RESET = 24'h010410;
   localparam logic [15:0] TLIMIT_RESET = 16'hffff;
   localparam logic [7:0] LOAD_FULL = 8'h64;
   localparam logic [7:0] STAGE2_MIN = 8'h22;
   localparam logic [7:0] STAGE3_MIN = 8'h43;
   localparam logic [15:0] HEAT_HYST = 16'h0010;
   localparam int INTEG_LIMIT = 1048575;
   localparam int unsigned PID_SHIFT = 8;

   typedef enum logic [2:0] {
      NO_LOOP_MODE = 3'h0,
      EXTERNAL_CONTACT_LOOP_MODE = 3'h1,
      INTERNAL_LOOP_MODE = 3'h2,
      INTERNAL_LOOP_BUS_SETPOINT_MODE = 3'h3,
      INTERNAL_LOOP_ANALOG_SETPOINT_MODE = 3'h4,
      EXTERNAL_ANALOG_LOAD_MODE = 3'h5,
      EXTERNAL_BUS_LOAD_MODE = 3'h6
   } lss_mode_t;

   typedef enum logic [1:0] {
      RUN_OFF = 2'h0,
      RUN_MANUAL = 2'h1,
      RUN_AUTO = 2'h2
   } lss_run_t;

   typedef struct packed {
      lss_mode_t mode;
      logic [1:0] ctrl;
      logic [9:0] manual;
      logic [15:0] sp1;
      logic [15:0] sp2;
      logic [15:0] bus_sp;
      logic [8:0] bus_load;
      logic [15:0] range;
      logic [23:0] gain;
      logic [15:0] tlimit;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [1:0] co_s;
      logic [2:0] hd_s1;
      logic [2:0] hd_s2;
      logic [1:0] start_s;
      logic [1:0] ph21_s;
      logic [1:0] oil_s;
      logic [1:0] press_s;
      logic [1:0] run_s1;
      lss_run_t run_s2;
      logic [15:0] asp_s1;
      logic [15:0] asp_s2;
      logic [7:0] aload_s1;
      logic [7:0] aload_s2;
      logic [15:0] temp_s1;
      logic [15:0] temp_s2;
      logic [15:0] pres_s1;
      logic [15:0] pres_s2;
      logic [23:0] deb_cnt;
      logic co_db;
      logic [23:0] tick_cnt;
      logic signed [23:0] integ;
      logic signed [17:0] prev_err;
      logic [7:0] pid_load;
      logic heat_int;
      logic [7:0] ramp;
      logic [7:0] load;
      logic [1:0] stage;
      logic heat_req;
      logic start;
      logic standby;
      logic err;
      logic can_valid;
      logic [7:0] can_load;
      logic mode_upd;
      logic [15:0] setpoint;
      logic pid_active;
      logic tlim_active;
      logic multistage;
   } lss_state_t;

   localparam lss_state_t STATE_RESET = '{
      mode: INTERNAL_LOOP_MODE, run_s2: RUN_OFF, range: RANGE_RESET,
      gain: GAIN_RESET, tlimit: TLIMIT_RESET, standby: 1'b1, default: '0};
endpackage

// ==== src/lss_selector.sv ====
// load control source selector with apb register file
`timescale 1ns/1ps
module lss_selector #(
   parameter int unsigned DEBOUNCE_CYCLES = lss_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned SAMPLE_CYCLES = lss_pkg::SAMPLE_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // contacts and selectors
   input wire logic changeover_contact_input_in,
   input wire logic [2:0] heat_demand_input_in,
   input wire logic start_release_in,
   input wire logic phase_21_in,
   input wire logic fuel_is_oil_in,
   input wire logic [1:0] run_selector_in,
   // analog and sensor words
   input wire logic [15:0] analog_setpoint_in,
   input wire logic [7:0] analog_load_in,
   input wire logic [15:0] temp_value_in,
   input wire logic [15:0] pressure_value_in,
   input wire logic sensor_is_pressure_in,
   // internal bus mode broadcast
   output logic [2:0] loop_source_mode_out,
   output logic mode_update_out,
   // burner side
   output logic [7:0] load_out,
   output logic [1:0] stage_out,
   output logic heat_request_out,
   output logic burner_start_out,
   output logic standby_out,
   output logic error_out,
   output logic [15:0] setpoint_out,
   output logic pid_active_out,
   output logic temp_limit_active_out,
   output logic multistage_out,
   output logic can_load_valid_out,
   output logic [7:0] can_load_out
);
   localparam int INTEG_LIM = lss_pkg::INTEG_LIMIT;

   lss_pkg::lss_state_t r;
   lss_pkg::lss_state_t n;
   logic apb_wr;

   function automatic logic [7:0] lss_clamp(input logic signed [31:0] v, input logic [7:0] lo,
                                            input logic [7:0] hi);
      logic [7:0] top;
      top = (hi > lss_pkg::LOAD_FULL) ? lss_pkg::LOAD_FULL : hi;
      if (v < $signed({24'h000000, lo}))
         lss_clamp = lo;
      else if (v > $signed({24'h000000, top}))
         lss_clamp = top;
      else
         lss_clamp = v[7:0];
   endfunction

   function automatic logic [1:0] lss_stage_of(input logic [7:0] load);
      if (load < lss_pkg::STAGE2_MIN)
         lss_stage_of = 2'h1;
      else if (load < lss_pkg::STAGE3_MIN)
         lss_stage_of = 2'h2;
      else
         lss_stage_of = 2'h3;
   endfunction

   // writes land only on the edge where the master samples pready
   assign apb_wr = psel_in && penable_in && r.pready && pwrite_in && !r.pslverr;

   always_comb
   begin
      logic co;
      logic internal;
      logic tick;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [15:0] actual;
      logic signed [17:0] dev;
      logic signed [31:0] isum;
      logic signed [31:0] u;
      logic [7:0] src_load;
      logic src_heat;
      logic demand;
      logic [7:0] aload;
      logic rd_hit;
      logic [31:0] rd_data;
      co = 1'b0;
      internal = 1'b0;
      tick = 1'b0;
      lo = 8'h00;
      hi = 8'h00;
      actual = 16'h0000;
      dev = '0;
      isum = '0;
      u = '0;
      src_load = 8'h00;
      src_heat = 1'b0;
      demand = 1'b0;
      aload = 8'h00;
      rd_hit = 1'b0;
      rd_data = 32'h00000000;
      n = r;
      // pin synchronisers, the first stage feeds only the second
      n.co_s = {r.co_s[0], changeover_contact_input_in};
      n.hd_s1 = heat_demand_input_in;
      n.hd_s2 = r.hd_s1;
      n.start_s = {r.start_s[0], start_release_in};
      n.ph21_s = {r.ph21_s[0], phase_21_in};
      n.oil_s = {r.oil_s[0], fuel_is_oil_in};
      n.press_s = {r.press_s[0], sensor_is_pressure_in};
      n.run_s1 = run_selector_in;
      n.run_s2 = lss_pkg::lss_run_t'(r.run_s1);
      // analog words are assumed to settle slowly against the clock
      n.asp_s1 = analog_setpoint_in;
      n.asp_s2 = r.asp_s1;
      n.aload_s1 = analog_load_in;
      n.aload_s2 = r.aload_s1;
      n.temp_s1 = temp_value_in;
      n.temp_s2 = r.temp_s1;
      n.pres_s1 = pressure_value_in;
      n.pres_s2 = r.pres_s1;
      // contact must hold its new level for the whole window
      if (r.co_s[1] == r.co_db)
         n.deb_cnt = '0;
      else if (r.deb_cnt >= 24'(DEBOUNCE_CYCLES - 1))
      begin
         n.deb_cnt = '0;
         n.co_db = r.co_s[1];
      end
      else
         n.deb_cnt = r.deb_cnt + 24'h000001;
      co = r.co_db;
      // loop sample tick
      tick = (r.tick_cnt >= 24'(SAMPLE_CYCLES - 1));
      n.tick_cnt = tick ? '0 : r.tick_cnt + 24'h000001;
      lo = r.range[7:0];
      hi = r.range[15:8];
      actual = r.press_s[1] ? r.pres_s2 : r.temp_s2;
      // closed contact forces the internal loop from any mode
      internal = co || (r.mode == lss_pkg::INTERNAL_LOOP_MODE) ||
                 (r.mode == lss_pkg::INTERNAL_LOOP_BUS_SETPOINT_MODE) ||
                 (r.mode == lss_pkg::INTERNAL_LOOP_ANALOG_SETPOINT_MODE) ||
                 (r.mode == lss_pkg::NO_LOOP_MODE) || (r.mode > lss_pkg::EXTERNAL_BUS_LOAD_MODE);
      case (r.mode)
         lss_pkg::INTERNAL_LOOP_MODE: n.setpoint = co ? r.sp2 : r.sp1;
         lss_pkg::INTERNAL_LOOP_BUS_SETPOINT_MODE: n.setpoint = co ? r.sp1 : r.bus_sp;
         lss_pkg::INTERNAL_LOOP_ANALOG_SETPOINT_MODE: n.setpoint = co ? r.sp1 : r.asp_s2;
         default: n.setpoint = r.sp1;
      endcase
      n.pid_active = internal;
      // two position heat request with a small differential
      if (actual < r.setpoint)
         n.heat_int = 1'b1;
      else if ({1'b0, actual} >= {1'b0, r.setpoint} + {1'b0, lss_pkg::HEAT_HYST})
         n.heat_int = 1'b0;
      // limiter flag follows its enable bit whether or not the loop runs, but its cut acts only on the internal heat request
      n.tlim_active = r.ctrl[lss_pkg::CTRL_TLIM_BIT];
      if (r.tlim_active && actual >= r.tlimit)
         n.heat_int = 1'b0;
      // pid law, integrator cleared while the loop is idle
      dev = $signed({2'b00, r.setpoint}) - $signed({2'b00, actual});
      if (!r.pid_active)
      begin
         n.integ = '0;
         n.prev_err = '0;
         n.pid_load = lo;
      end
      else if (tick)
      begin
         isum = 32'(r.integ) + 32'(dev);
         if (isum > INTEG_LIM)
            isum = INTEG_LIM;
         else if (isum < -INTEG_LIM)
            isum = -INTEG_LIM;
         n.integ = 24'(isum);
         u = $signed({24'h000000, r.gain[7:0]}) * 32'(dev) +
             $signed({24'h000000, r.gain[15:8]}) * isum +
             $signed({24'h000000, r.gain[23:16]}) * (32'(dev) - 32'(r.prev_err));
         n.pid_load = lss_clamp(u >>> lss_pkg::PID_SHIFT, lo, hi);
         n.prev_err = dev;
      end
      // contact controller ramps the load on each tick
      if (tick && r.hd_s2[1] && !r.hd_s2[2] && r.ramp < hi && r.ramp < lss_pkg::LOAD_FULL)
         n.ramp = r.ramp + 8'h01;
      else if (tick && r.hd_s2[2] && !r.hd_s2[1] && r.ramp > lo)
         n.ramp = r.ramp - 8'h01;
      else if (r.ramp < lo)
         n.ramp = lo;
      aload = lss_clamp(32'(r.aload_s2), lo, hi);
      if (internal)
      begin
         src_load = r.pid_load;
         src_heat = r.heat_int;
      end
      else
      begin
         case (r.mode)
            lss_pkg::EXTERNAL_CONTACT_LOOP_MODE:
            begin
               src_load = r.ramp;
               src_heat = r.hd_s2[0];
            end
            lss_pkg::EXTERNAL_ANALOG_LOAD_MODE:
            begin
               src_load = aload;
               src_heat = r.hd_s2[0];
            end
            lss_pkg::EXTERNAL_BUS_LOAD_MODE:
            begin
               src_load = lss_clamp(32'(r.bus_load[7:0]), lo, hi);
               src_heat = r.bus_load[lss_pkg::BUS_HEAT_BIT];
            end
            default:
            begin
               src_load = r.pid_load;
               src_heat = r.heat_int;
            end
         endcase
      end
      // load messages only on change, so the can side is not flooded
      n.can_valid = 1'b0;
      if (!internal && r.mode == lss_pkg::EXTERNAL_ANALOG_LOAD_MODE && aload != r.can_load)
      begin
         n.can_valid = 1'b1;
         n.can_load = aload;
      end
      // gas always modulates, oil as configured
      n.multistage = r.oil_s[1] && r.ctrl[lss_pkg::CTRL_OIL_STAGE_BIT];
      case (r.run_s2)
         lss_pkg::RUN_MANUAL:
         begin
            demand = r.hd_s2[0];
            n.start = r.hd_s2[0] && r.start_s[1] && r.ph21_s[1];
            n.load = lss_clamp(32'(r.manual[7:0]), lo, hi);
            if (!r.multistage)
               n.stage = 2'h0;
            else if (r.manual[9:8] != 2'h0)
               n.stage = r.manual[9:8];
            else
               n.stage = lss_stage_of(n.load);
            n.err = (r.mode == lss_pkg::NO_LOOP_MODE) || (r.mode > lss_pkg::EXTERNAL_BUS_LOAD_MODE);
         end
         lss_pkg::RUN_AUTO:
         begin
            demand = src_heat;
            n.start = src_heat && r.start_s[1] && r.ph21_s[1];
            n.load = src_load;
            n.stage = r.multistage ? lss_stage_of(src_load) : 2'h0;
            n.err = (r.mode == lss_pkg::NO_LOOP_MODE) || (r.mode > lss_pkg::EXTERNAL_BUS_LOAD_MODE);
         end
         default:
         begin
            demand = 1'b0;
            n.start = 1'b0;
            n.load = 8'h00;
            n.stage = 2'h0;
            n.err = 1'b0;
         end
      endcase
      n.heat_req = demand;
      n.standby = !n.start;
      // apb: one wait state, data and answer both from flops
      case (paddr_in)
         lss_pkg::MODE_OFS: rd_data = {29'h0, r.mode};
         lss_pkg::CTRL_OFS: rd_data = {30'h0, r.ctrl};
         lss_pkg::MANUAL_OFS: rd_data = {22'h0, r.manual};
         lss_pkg::SP1_OFS: rd_data = {16'h0, r.sp1};
         lss_pkg::SP2_OFS: rd_data = {16'h0, r.sp2};
         lss_pkg::BUS_SP_OFS: rd_data = {16'h0, r.bus_sp};
         lss_pkg::BUS_LOAD_OFS: rd_data = {23'h0, r.bus_load};
         lss_pkg::RANGE_OFS: rd_data = {16'h0, r.range};
         lss_pkg::GAIN_OFS: rd_data = {8'h0, r.gain};
         lss_pkg::TLIMIT_OFS: rd_data = {16'h0, r.tlimit};
         lss_pkg::STATUS_OFS: rd_data = {14'h0, r.load, r.multistage, r.standby, r.heat_req,
                                         r.pid_active, r.co_db, r.run_s2, r.mode};
         default: rd_data = 32'h00000000;
      endcase
      rd_hit = (paddr_in <= lss_pkg::STATUS_OFS) && (paddr_in[1:0] == 2'h0);
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel_in && penable_in && !r.pready)
      begin
         n.pready = 1'b1;
         n.pslverr = !rd_hit;
         n.prdata = (pwrite_in || !rd_hit) ? 32'h00000000 : rd_data;
      end
      n.mode_upd = 1'b0;
      if (apb_wr)
      begin
         case (paddr_in)
            lss_pkg::MODE_OFS:
            begin
               n.mode = lss_pkg::lss_mode_t'(pwdata_in[2:0]);
               n.mode_upd = 1'b1;
            end
            lss_pkg::CTRL_OFS: n.ctrl = pwdata_in[1:0];
            lss_pkg::MANUAL_OFS: n.manual = pwdata_in[9:0];
            lss_pkg::SP1_OFS: n.sp1 = pwdata_in[15:0];
            lss_pkg::SP2_OFS: n.sp2 = pwdata_in[15:0];
            lss_pkg::BUS_SP_OFS: n.bus_sp = pwdata_in[15:0];
            lss_pkg::BUS_LOAD_OFS: n.bus_load = pwdata_in[8:0];
            lss_pkg::RANGE_OFS: n.range = pwdata_in[15:0];
            lss_pkg::GAIN_OFS: n.gain = pwdata_in[23:0];
            lss_pkg::TLIMIT_OFS: n.tlimit = pwdata_in[15:0];
            default: n.ctrl = r.ctrl; // status ignores writes
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         r <= lss_pkg::STATE_RESET;
      else
         r <= n;
   end

   assign prdata_out = r.prdata;
   assign pready_out = r.pready;
   assign pslverr_out = r.pslverr;
   assign loop_source_mode_out = r.mode;
   assign mode_update_out = r.mode_upd;
   assign load_out = r.load;
   assign stage_out = r.stage;
   assign heat_request_out = r.heat_req;
   assign burner_start_out = r.start;
   assign standby_out = r.standby;
   assign error_out = r.err;
   assign setpoint_out = r.setpoint;
   assign pid_active_out = r.pid_active;
   assign temp_limit_active_out = r.tlim_active;
   assign multistage_out = r.multistage;
   assign can_load_valid_out = r.can_valid;
   assign can_load_out = r.can_load;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   mode_bcast_a: assert property (apb_wr && paddr_in == lss_pkg::MODE_OFS |=>
         mode_update_out && loop_source_mode_out == $past(pwdata_in[2:0]))
      else $error("mode write not broadcast");
   contact_idle_a: assert property (r.mode == lss_pkg::EXTERNAL_CONTACT_LOOP_MODE &&
         !r.co_db |=> !pid_active_out)
      else $error("loop active in contact mode");
   limiter_free_a: assert property (r.mode == lss_pkg::EXTERNAL_CONTACT_LOOP_MODE |=>
         temp_limit_active_out == $past(r.ctrl[lss_pkg::CTRL_TLIM_BIT]))
      else $error("limiter enable not honoured");
   internal_run_a: assert property (r.mode == lss_pkg::INTERNAL_LOOP_MODE |=> pid_active_out)
      else $error("internal loop not active");
   sp_pick_a: assert property (r.mode == lss_pkg::INTERNAL_LOOP_MODE |=>
         setpoint_out == ($past(r.co_db) ? $past(r.sp2) : $past(r.sp1)))
      else $error("wrong internal setpoint");
   bus_fallback_a: assert property (r.mode == lss_pkg::INTERNAL_LOOP_BUS_SETPOINT_MODE &&
         r.co_db |=> setpoint_out == $past(r.sp1))
      else $error("bus setpoint not replaced");
   analog_sp_a: assert property (r.mode == lss_pkg::INTERNAL_LOOP_ANALOG_SETPOINT_MODE &&
         !r.co_db |=> setpoint_out == $past(r.asp_s2))
      else $error("analog setpoint not used");
   can_source_a: assert property (can_load_valid_out |->
         $past(r.mode) == lss_pkg::EXTERNAL_ANALOG_LOAD_MODE && !$past(r.co_db) && !pid_active_out)
      else $error("load message outside analog load mode");
   off_standby_a: assert property (r.run_s2 == lss_pkg::RUN_OFF |=>
         standby_out && !burner_start_out && !error_out)
      else $error("run off not in standby");
   manual_start_a: assert property (r.run_s2 == lss_pkg::RUN_MANUAL |=>
         burner_start_out == $past(r.hd_s2[0] && r.start_s[1] && r.ph21_s[1]))
      else $error("manual start condition wrong");
   manual_range_a: assert property (r.run_s2 == lss_pkg::RUN_MANUAL |=>
         load_out >= $past(r.range[7:0]) && load_out <= lss_pkg::LOAD_FULL)
      else $error("manual load out of range");
   auto_start_a: assert property (burner_start_out |->
         $past(r.start_s[1]) && $past(r.ph21_s[1]) && $past(r.run_s2) != lss_pkg::RUN_OFF)
      else $error("start without release");
   gas_mod_a: assert property (!r.oil_s[1] |=> !multistage_out)
      else $error("gas not modulating");
   debounce_hold_a: assert property ($changed(r.co_db) |->
         $past(r.deb_cnt) == 24'(DEBOUNCE_CYCLES - 1) && r.co_db == $past(r.co_s[1]))
      else $error("contact changed without debounce");

   fallback_c: cover property (r.mode == lss_pkg::EXTERNAL_BUS_LOAD_MODE && $rose(r.co_db));
   can_msg_c: cover property (can_load_valid_out);
   auto_start_c: cover property (r.run_s2 == lss_pkg::RUN_AUTO && $rose(burner_start_out));
endmodule

// ==== bench/lss_bas_model.sv ====
// model of the automation side feeding contact, demand contacts and analog words
`timescale 1ns/1ps
module lss_bas_model (
   // clock
   input wire logic clk_in,
   // commands from the bench
   input wire logic close_in,
   input wire logic [2:0] demand_in,
   input wire logic [15:0] sp_in,
   input wire logic [7:0] load_in,
   // lines into the device
   output logic contact_out = 1'b0,
   output logic [2:0] contacts_out = 3'h0,
   output logic [15:0] sp_out = 16'h0000,
   output logic [7:0] load_out = 8'h00
);
   // relay outputs move just after the edge, never mid-cycle
   always @(posedge clk_in)
   begin
      contact_out <= close_in;
      contacts_out <= demand_in;
      sp_out <= sp_in;
      load_out <= load_in;
   end
endmodule

// ==== bench/tb_load_control_source_selector.sv ====
// self-checking bench of the load control source selector
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb_load_control_source_selector;
   logic clk_in = 0, nrst_in = 0, psel = 0, pen = 0, pwr = 0, co = 0, sr = 0, ph = 0, oil = 0;
   logic psn = 0;
   logic [7:0] pa = 8'h00, ld = 8'h00, lo, cl, ald;
   logic [31:0] pwd = 32'h0, rd, prd;
   logic [2:0] dm = 3'h0, mo, hd;
   logic [1:0] run = 2'h0, stg;
   logic [15:0] sp = 16'h0000, spo, asp;
   logic er, prdy, perr, mupd, hreq, bst, stb, err, pida, tla, ms, cv, cco;
   int n_fail = 0, compares = 0;
   always #12.5 clk_in = ~clk_in;
   lss_bas_model u_bas (.clk_in(clk_in), .close_in(co), .demand_in(dm), .sp_in(sp),
      .load_in(ld), .contact_out(cco), .contacts_out(hd), .sp_out(asp), .load_out(ald));
   lss_selector #(.DEBOUNCE_CYCLES(4), .SAMPLE_CYCLES(16)) u_dut (.clk_in(clk_in),
      .nrst_in(nrst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
      .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
      .changeover_contact_input_in(cco), .heat_demand_input_in(hd), .start_release_in(sr),
      .phase_21_in(ph), .fuel_is_oil_in(oil), .run_selector_in(run),
      .analog_setpoint_in(asp), .analog_load_in(ald), .temp_value_in(16'h0000),
      .pressure_value_in(16'hffff), .sensor_is_pressure_in(psn),
      .loop_source_mode_out(mo), .mode_update_out(mupd), .load_out(lo), .stage_out(stg),
      .heat_request_out(hreq), .burner_start_out(bst), .standby_out(stb), .error_out(err),
      .setpoint_out(spo), .pid_active_out(pida), .temp_limit_active_out(tla),
      .multistage_out(ms), .can_load_valid_out(cv), .can_load_out(cl));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      @(posedge clk_in);
      // answer time is the slave's, only the watchdog ends this wait
      while (prdy !== 1'b1)
      begin
         @(posedge clk_in);
      end
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // pins need 3 edges, the contact 2 + debounce + 1 more, model adds one
   task automatic wt(input int c);
      repeat (c) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic t_regs();
      `CHK(mo, 3'h2)
      apb(0, 8'h1c, 0);
      `CHK(rd[15:0], 16'h6400)
      apb(0, 8'h2c, 0);
      `CHK(er, 1'b1)
      run <= 2'h1;
      apb(1, 8'h28, 32'h0);
      apb(0, 8'h28, 0);
      `CHK(rd[4:3], 2'h1)
      apb(1, 8'h08, 32'h32);
      apb(0, 8'h08, 0);
      `CHK(rd[9:0], 10'h032)
   endtask
   task automatic t_modes();
      for (int m = 1; m < 7; m++)
      begin
         apb(1, 8'h00, 32'(m));
         @(negedge clk_in);
         `CHK(mupd, 1'b1)
         `CHK(mo, 3'(m))
      end
   endtask
   task automatic t_run();
      apb(1, 8'h00, 32'h2);
      dm <= 3'h1;
      sr <= 1'b1;
      ph <= 1'b1;
      wt(6);
      `CHK(bst, 1'b1)
      `CHK(lo, 8'h32)
      apb(1, 8'h08, 32'h96);
      wt(4);
      `CHK(lo, 8'h64)
      @(posedge clk_in);
      run <= 2'h0;
      wt(6);
      `CHK({bst, stb, err}, 3'b010)
      apb(1, 8'h18, 32'h128);
      apb(1, 8'h00, 32'h6);
      run <= 2'h2;
      wt(6);
      `CHK({bst, hreq, lo}, {2'b11, 8'h28})
      @(posedge clk_in);
      sr <= 1'b0;
      wt(6);
      `CHK(bst, 1'b0)
   endtask
   task automatic t_sp();
      apb(1, 8'h0c, 32'h100);
      apb(1, 8'h10, 32'h200);
      apb(1, 8'h14, 32'h300);
      sp <= 16'h0400;
      apb(1, 8'h00, 32'h2);
      wt(4);
      `CHK({pida, hreq, spo}, 18'h30100)
      @(posedge clk_in);
      psn <= 1'b1;
      wt(6);
      `CHK(hreq, 1'b0)
      @(posedge clk_in);
      co <= 1'b1;
      wt(12);
      `CHK(spo, 16'h0200)
      apb(1, 8'h00, 32'h3);
      wt(4);
      `CHK(spo, 16'h0100)
      apb(1, 8'h00, 32'h5);
      wt(4);
      `CHK({pida, spo}, 17'h10100)
      apb(1, 8'h00, 32'h3);
      co <= 1'b0;
      wt(12);
      `CHK(spo, 16'h0300)
      apb(1, 8'h00, 32'h4);
      wt(4);
      `CHK(spo, 16'h0400)
   endtask
   task automatic t_ext();
      int n = 0;
      oil <= 1'b1;
      apb(1, 8'h04, 32'h3);
      apb(1, 8'h00, 32'h1);
      wt(6);
      `CHK({pida, tla, ms}, 3'b011)
      `CHK(stg, 2'h1)
      @(posedge clk_in);
      dm <= 3'h3;
      wt(40);
      `CHK(lo >= 8'h02 && lo <= 8'h03, 1'b1)
      @(posedge clk_in);
      ld <= 8'h28;
      apb(1, 8'h00, 32'h5);
      while (cv !== 1'b1 && n < 60)
      begin
         @(negedge clk_in);
         n++;
      end
      `CHK({cv, pida, cl}, {2'b10, 8'h28})
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_regs();
      t_modes();
      t_run();
      t_sp();
      t_ext();
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      tally_and_finish();
   end
endmodule
